// File: design/crpc_pkg.sv
// crpc_pkg: shared constants, types and register map for the clock, role and power control block.
// assumes a 125 MHz system clock and an AHB-Lite slave with 32-bit data.
package crpc_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CLKDIV  = 8'h00;  // clock divider command
  localparam logic [7:0] ADDR_LUMA    = 8'h04;  // luminance set command a
  localparam logic [7:0] ADDR_LUMB    = 8'h08;  // luminance set command b
  localparam logic [7:0] ADDR_VFDET   = 8'h0C;  // forward voltage detect command
  localparam logic [7:0] ADDR_CONV    = 8'h10;  // converter control command
  localparam logic [7:0] ADDR_STATUS  = 8'h14;  // read-only status

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LUM_SRC_BIT   = 7;  // luminance source select, 1 = host register
  localparam int CONV_EN_BIT   = 0;  // converter enable bit
  localparam int CONV_FRQ_LSB  = 1;  // switching frequency field, 2 bits
  localparam int ST_ROLE_LSB   = 0;
  localparam int ST_SRC_BIT    = 2;
  localparam int ST_GATE_BIT   = 3;
  localparam int ST_LATCH_BIT  = 4;
  localparam int ST_UVLO_BIT   = 5;
  localparam int ST_LOOP_BIT   = 6;
  localparam int ST_OPEN_BIT   = 7;
  localparam int ST_VFLT_BIT   = 8;
  localparam int ST_MODE_BIT   = 9;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [2:0] CLKDIV_RST  = 3'h0;
  localparam logic [7:0] LUM_RST     = 8'h00;  // source select low: memory value
  localparam logic [2:0] FORWARD_VOLTAGE_OFFSET_FIELD_RST    = 3'h0;
  localparam logic [1:0] FRQ_RST     = 2'h0;   // code 0 is the default rate
  localparam int         OC_CYCLES   = 16;     // persisting overcurrent, internal cycles
  localparam int         FILT_LEN    = 4;      // glitch filter on analog comparator flags
  localparam int         FORWARD_VOLTAGE_OFFSET_FIELD_MV_LSB = 286;    // offset step in millivolts

  typedef enum logic [1:0] {
    CRPC_LOWER_FOLLOWER = 2'b00,
    CRPC_LOWER_LEADER   = 2'b01,
    CRPC_UPPER_FOLLOWER = 2'b10,
    CRPC_UPPER_LEADER   = 2'b11
  } crpc_role_e;

  // analog comparator flags from the converter front end
  typedef struct packed {
    logic uvOff;      // gate supply below off threshold
    logic uvOn;       // gate supply above on threshold
    logic overCur;    // switch current sense trip
    logic openStart;  // open loop on startup feedback sense
    logic openSteady; // open loop on steady feedback sense
    logic steady;     // output judged at steady state
    logic overVolt;   // boosted output above clamp maximum
  } crpc_conv_s;

  // outputs toward the analog converter
  typedef struct packed {
    logic       gateEn;
    logic       constOnTime;
    logic       steadyLoop;
    logic [1:0] freqSel;
    logic [2:0] fwdOffset;
  } crpc_drive_s;

endpackage : crpc_pkg

// File: design/crpc_sync.sv
// crpc_sync: two flip-flop synchroniser for a vector of levels.
// assumes inputs arrive from outside the mclk domain.
`timescale 1ns/1ns
module crpc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : crpc_sync

// File: design/crpc_prescaler.sv
// crpc_prescaler: power-of-two divider of the sampled oscillator.
// assumes oscEdge is a one-cycle pulse on mclk per oscillator edge, rising or falling.
`timescale 1ns/1ns
module crpc_prescaler (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       oscEdge,
  input  wire logic [2:0] divExp,
  output logic            divClk,
  output logic            divTick
);
  import crpc_pkg::*;

  logic [6:0] cnt_q;
  logic [2:0] expAct_q;
  logic       wrap;
  logic [6:0] limit;

  // half period is 2^n oscillator edges, so n=0 passes the oscillator through
  assign limit = 7'((8'h01 << expAct_q) - 8'h01);
  assign wrap  = oscEdge && (cnt_q >= limit);

  // new exponent only taken at a wrap that drives the output low, so no runt pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 7'h00;
      expAct_q <= CLKDIV_RST;
      divClk   <= 1'b0;
      divTick  <= 1'b0;
    end else begin
      divTick <= wrap && !divClk;
      if (wrap) begin
        cnt_q  <= 7'h00;
        divClk <= !divClk;
        if (divClk) expAct_q <= divExp;
      end else if (oscEdge) begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end
endmodule : crpc_prescaler

// File: design/crpc_top.sv
// crpc_top: clock source, prescaler, cascade role, luminance source and converter supervision.
// assumes pads and analog flags are asynchronous to mclk; registers reached over AHB-Lite.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - clock source from external path or internal oscillator, by clock pad and role pad bit 0.
// - internal oscillator is the nominal 4.8 MHz reference when selected.
// - internal system clock is driven to slaves on the clock output.
// - oscillator divided by two to the power of the 3-bit exponent.
// - role decoded from two role pads into four cascade roles.
// - followers take interface signals from their leader and run in step.
// - lower leader drives a sync output toward the lower follower.
// - only upper leader activates frame, line, forward and first row control outputs.
// - leaders answer first chip select, followers the second.
// - each DAC takes 7 bits from host register or memory by select bit.
// - after reset the DAC source is the one-time memory.
// - two independent luminance channels a and b.
// - 3-bit forward voltage offset field drives the offset DAC.
// - output over clamp maximum drives second row control high.
// - converter mode from mode pad.
// - startup loop at power-on, steady loop once steady state reached.
// - undervoltage lockout with hysteresis, glitches filtered.
// - gate drive off while overcurrent is reported.
// - 16 consecutive overcurrent cycles latch gate off until reset.
// - open loop on either sense input shuts gate drive.
// - mode pad low constant frequency, high constant on-time.
// - frequency field default code gives the default rate, host may change it.
// - converter enable starts converter; latched shutdown blocks restart.
module crpc_top #(
  parameter int FILT = crpc_pkg::FILT_LEN
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // pads
  input  wire logic                 externalClockInput,
  input  wire logic                 internalOscClock,
  input  wire logic                 clockSourceSelectPad,
  input  wire logic [1:0]           roleSelectPads,
  input  wire logic                 converterModePad,
  input  wire logic                 leaderChipSelect_n,
  input  wire logic                 followerChipSelect_n,
  input  wire logic                 syncFromLeader,
  input  wire logic [6:0]           memLumA,
  input  wire logic [6:0]           memLumB,
  input  wire crpc_pkg::crpc_conv_s convFlags,
  // outputs
  output logic                      clockOutToSlaves,
  output logic                      sysTick,
  output logic                      hostSelected,
  output logic                      followerSyncOut,
  output logic                      frameSyncOutputEn,
  output logic                      lineSyncOutputEn,
  output logic                      serialForwardOutputEn,
  output logic                      rowControlFirstEn,
  output logic                      rowControlSecond,
  output logic                      rowControlSecondEn,
  output logic      [6:0]           dacA,
  output logic      [6:0]           dacB,
  output crpc_pkg::crpc_drive_s     drive
);
  import crpc_pkg::*;

  // ****************************************************************
  // pad synchronisers
  // ****************************************************************
  logic [6:0] padS;
  logic [6:0] flagS;
  logic       extS, intS, clkPadS, modeS, leadCsS, follCsS, syncS;
  logic [1:0] roleS;

  // every pad and analog flag except memLumA and memLumB passes two flops first
  crpc_sync #(.W(7)) u_padsync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    ({externalClockInput, internalOscClock, clockSourceSelectPad, roleSelectPads, converterModePad,
              syncFromLeader}),
    .dout   (padS)
  );
  crpc_sync #(.W(7)) u_flagsync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    (convFlags),
    .dout   (flagS)
  );
  logic [1:0] csS;
  crpc_sync #(.W(2)) u_cssync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    ({leaderChipSelect_n, followerChipSelect_n}),
    .dout   (csS)
  );
  assign {extS, intS, clkPadS, roleS, modeS, syncS} = padS;
  assign {leadCsS, follCsS} = csS;

  // ****************************************************************
  // straps caught after reset release
  // ****************************************************************
  logic [1:0] role_q;
  logic       srcInt_q;
  logic [1:0] strapCnt_q;
  logic       strapDone_q;

  // wait for the synchroniser to fill, then freeze the straps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strapCnt_q  <= 2'h0;
      strapDone_q <= 1'b0;
      role_q      <= 2'h0;
      srcInt_q    <= 1'b0;
    end else if (!strapDone_q) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == 2'h3) begin
        strapDone_q <= 1'b1;
        role_q      <= roleS;
        srcInt_q    <= clkPadS & roleS[0];
      end
    end
  end

  crpc_role_e role;
  assign role = crpc_role_e'(role_q);

  // ****************************************************************
  // clock source and prescaler
  // ****************************************************************
  logic srcClk, srcClk_q, oscEdge, divClk, divTick;
  logic [2:0] divExp_q;

  // internal oscillator used when selected, external path otherwise
  assign srcClk  = srcInt_q ? intS : extS;
  assign oscEdge = srcClk ^ srcClk_q; // both edges, so exponent 0 gives ratio 1/1

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) srcClk_q <= 1'b0;
    else         srcClk_q <= srcClk;
  end

  crpc_prescaler u_presc (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .oscEdge (oscEdge),
    .divExp  (divExp_q),
    .divClk  (divClk),
    .divTick (divTick)
  );

  // ****************************************************************
  // ahb-lite register slave
  // ****************************************************************
  logic        wrPend_q;
  logic [7:0]  wrAddr_q;
  logic [7:0]  lumA_q, lumB_q;
  logic [2:0]  forward_voltage_offset_field_q;
  logic        convEn_q;
  logic [1:0]  freq_q;
  logic        accept;
  logic [31:0] statusWord, readWord;

  assign accept = hsel && hready && htrans[1];

  // writes land in the data phase; reads answered without wait
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= accept && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // command registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divExp_q <= CLKDIV_RST;
      lumA_q   <= LUM_RST;
      lumB_q   <= LUM_RST;
      forward_voltage_offset_field_q   <= FORWARD_VOLTAGE_OFFSET_FIELD_RST;
      convEn_q <= 1'b0;
      freq_q   <= FRQ_RST;
    end else if (wrPend_q) begin
      unique case (wrAddr_q)
        ADDR_CLKDIV: divExp_q <= hwdata[2:0];
        ADDR_LUMA:   lumA_q   <= hwdata[7:0];
        ADDR_LUMB:   lumB_q   <= hwdata[7:0];
        ADDR_VFDET:  forward_voltage_offset_field_q   <= hwdata[2:0];
        ADDR_CONV: begin
          convEn_q <= hwdata[CONV_EN_BIT];
          freq_q   <= hwdata[CONV_FRQ_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // converter supervision
  // ****************************************************************
  logic [FILT-1:0] uvHist_q, ocHist_q, opHist_q;
  logic            uvLock_q, ocNow, openNow, ocLatch_q, steady_q, convRun_q, gate;
  logic [4:0]      ocCnt_q;
  logic            fUvOff, fUvOn, fOc, fOpS, fOpH, fSteady, fOv;

  assign {fUvOff, fUvOn, fOc, fOpS, fOpH, fSteady, fOv} = flagS;

  // shift histories, undervoltage-off and open-loop flags count only when steady over the window
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      uvHist_q <= '0;
      ocHist_q <= '0;
      opHist_q <= '0;
    end else begin
      uvHist_q <= {uvHist_q[FILT-2:0], fUvOff};
      ocHist_q <= {ocHist_q[FILT-2:0], fOc};
      opHist_q <= {opHist_q[FILT-2:0], fOpS | fOpH};
    end
  end
  assign ocNow   = fOc;
  assign openNow = &opHist_q;

  // lockout with hysteresis: off below low threshold, back on only above high one
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)                  uvLock_q <= 1'b1;
    else if (&uvHist_q)           uvLock_q <= 1'b1;
    else if (fUvOn && !fUvOff)    uvLock_q <= 1'b0;
  end

  // overcurrent persistence counted in divided-clock cycles, then latched
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ocCnt_q   <= 5'h00;
      ocLatch_q <= 1'b0;
    end else begin
      if (!ocNow)          ocCnt_q <= 5'h00;
      else if (divTick && ocCnt_q != 5'(OC_CYCLES)) ocCnt_q <= ocCnt_q + 5'h01;
      if (ocCnt_q == 5'(OC_CYCLES)) ocLatch_q <= 1'b1;
    end
  end

  // run state: enable starts with soft start in the analog; latch or disable stops it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      convRun_q <= 1'b0;
      steady_q  <= 1'b0;
    end else begin
      convRun_q <= convEn_q && !ocLatch_q;
      if (!convRun_q)   steady_q <= 1'b0;
      else if (fSteady) steady_q <= 1'b1;
    end
  end

  assign gate = convRun_q && !uvLock_q && !ocNow && !ocLatch_q && !openNow;

  // ****************************************************************
  // role-dependent and registered outputs
  // ****************************************************************
  logic upLead, loLead, leader, hostSel;
  assign upLead  = (role == CRPC_UPPER_LEADER);
  assign loLead  = (role == CRPC_LOWER_LEADER);
  assign leader  = role_q[0];
  assign hostSel = leader ? !leadCsS : !follCsS;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clockOutToSlaves      <= 1'b0;
      sysTick               <= 1'b0;
      hostSelected          <= 1'b0;
      followerSyncOut       <= 1'b0;
      frameSyncOutputEn     <= 1'b0;
      lineSyncOutputEn      <= 1'b0;
      serialForwardOutputEn <= 1'b0;
      rowControlFirstEn     <= 1'b0;
      rowControlSecond      <= 1'b0;
      rowControlSecondEn    <= 1'b0;
      dacA                  <= 7'h00;
      dacB                  <= 7'h00;
      drive                 <= '0;
    end else begin
      clockOutToSlaves      <= divClk;
      // followers step on the leader's sync pulse
      sysTick               <= leader ? divTick : syncS;
      hostSelected          <= hostSel && strapDone_q;
      followerSyncOut       <= loLead && divTick;
      frameSyncOutputEn     <= upLead;
      lineSyncOutputEn      <= upLead;
      serialForwardOutputEn <= upLead;
      rowControlFirstEn     <= upLead;
      rowControlSecondEn    <= upLead || fOv;
      rowControlSecond      <= fOv;
      dacA <= lumA_q[LUM_SRC_BIT] ? lumA_q[6:0] : memLumA;
      dacB <= lumB_q[LUM_SRC_BIT] ? lumB_q[6:0] : memLumB;
      drive.gateEn      <= gate;
      drive.constOnTime <= modeS;
      drive.steadyLoop  <= steady_q;
      drive.freqSel     <= freq_q;
      drive.fwdOffset   <= forward_voltage_offset_field_q;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  assign statusWord = {22'h0, modeS, fOv, openNow, steady_q, uvLock_q, ocLatch_q, gate, srcInt_q, role_q};
  assign readWord =
      (haddr[7:0] == ADDR_CLKDIV) ? {29'h0, divExp_q} :
      (haddr[7:0] == ADDR_LUMA)   ? {24'h0, lumA_q} :
      (haddr[7:0] == ADDR_LUMB)   ? {24'h0, lumB_q} :
      (haddr[7:0] == ADDR_VFDET)  ? {29'h0, forward_voltage_offset_field_q} :
      (haddr[7:0] == ADDR_CONV)   ? {29'h0, freq_q, convEn_q} :
      (haddr[7:0] == ADDR_STATUS) ? statusWord : 32'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (accept && !hwrite) hrdata <= readWord;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_latch_blocks;
    @(posedge mclk) disable iff (!arst_n) ocLatch_q |-> ##2 !drive.gateEn;
  endproperty
  a_latch_blocks: assert property (p_latch_blocks) else $error("gate on while latched");

  property p_latch_sticks;
    @(posedge mclk) disable iff (!arst_n) ocLatch_q |=> ocLatch_q;
  endproperty
  a_latch_sticks: assert property (p_latch_sticks) else $error("latch cleared without reset");

  property p_oc_gate;
    @(posedge mclk) disable iff (!arst_n) fOc |=> !drive.gateEn;
  endproperty
  a_oc_gate: assert property (p_oc_gate) else $error("gate on during overcurrent");

  property p_uv_gate;
    @(posedge mclk) disable iff (!arst_n) uvLock_q |=> !drive.gateEn;
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("gate on during lockout");

  property p_open_gate;
    @(posedge mclk) disable iff (!arst_n) openNow |=> !drive.gateEn;
  endproperty
  a_open_gate: assert property (p_open_gate) else $error("gate on with open loop");

  property p_role_outs;
    @(posedge mclk) disable iff (!arst_n) !upLead |=> !frameSyncOutputEn && !rowControlFirstEn;
  endproperty
  a_role_outs: assert property (p_role_outs) else $error("non-leader drives sync");

  property p_role_hold;
    @(posedge mclk) disable iff (!arst_n) strapDone_q |=> $stable(role_q) && $stable(srcInt_q);
  endproperty
  a_role_hold: assert property (p_role_hold) else $error("strap changed after capture");

  property p_dac_src;
    @(posedge mclk) disable iff (!arst_n) !lumA_q[LUM_SRC_BIT] |=> dacA == $past(memLumA);
  endproperty
  a_dac_src: assert property (p_dac_src) else $error("dac a not from memory");

  property p_overvolt;
    @(posedge mclk) disable iff (!arst_n) fOv |=> rowControlSecond && rowControlSecondEn;
  endproperty
  a_overvolt: assert property (p_overvolt) else $error("voltage fault not flagged");
endmodule : crpc_top

// File: bench/crpc_peer_model.sv
// crpc_peer_model: clock sources and the cascade leader's sync pulse.
// assumes nothing of the block; every output runs free of mclk.
`timescale 1ns/1ns
module crpc_peer_model (
  output logic extClk,
  output logic oscClk,
  output logic leaderSync
);
  // ****************************************
  // free-running sources
  // ****************************************
  // external clock path, 80 ns, phase unrelated to mclk
  initial begin
    extClk = 1'b0;
    #3;
    forever #40 extClk = ~extClk;
  end
  // integrated oscillator near 4.8 MHz
  initial begin
    oscClk = 1'b0;
    #5;
    forever #104 oscClk = ~oscClk;
  end
  // leader sync pulse once a microsecond, followers lock to it
  initial begin
    leaderSync = 1'b0;
    forever begin
      #917 leaderSync = 1'b1;
      #83 leaderSync = 1'b0;
    end
  end
endmodule : crpc_peer_model

// File: bench/clock_role_power_control_tb.sv
// clock_role_power_control_tb: self-checking bench for crpc_top.
// assumes crpc_pkg, crpc_top and crpc_peer_model are compiled first.
`timescale 1ns/1ns
`define CHECK_EQ(act, exp) begin nCompared++; if ((act) !== (exp)) begin nErrors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end
module clock_role_power_control_tb;
  import crpc_pkg::*;
  // ****************************************
  // signals, peer and design
  // ****************************************
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [18:0] e;} crpc_row_s;
  localparam logic [6:0] MEM_A = 7'h2A;
  localparam logic [6:0] MEM_B = 7'h15;
  logic        mclk, arst_n = 1'b0, hwrite = 1'b0, clkPad = 1'b0, modePad = 1'b0;
  logic        leadCs_n = 1'b1, follCs_n = 1'b1, hreadyout, hresp, clockOutToSlaves, sysTick;
  logic        hostSelected, followerSyncOut, frameEn, lineEn, fwdEn, rowFirstEn, rowSecond, rowSecondEn;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rdata, p;
  logic [1:0]  htrans = 2'h0, roleSelectPads = 2'h3;
  logic [6:0]  dacA, dacB;
  crpc_conv_s  flags = 7'h20;
  crpc_drive_s drive;
  wire         extClk, oscClk, leaderSync;
  int          nErrors = 0, nCompared = 0, nFollSync = 0, nTick = 0, fs0, tk0;
  crpc_row_s   rows [10] = '{'{ADDR_LUMA, 32'h85, {7'h05, MEM_B, 5'h00}},
    '{ADDR_LUMB, 32'hFF, {7'h05, 7'h7F, 5'h00}}, '{ADDR_VFDET, 32'h7, {7'h05, 7'h7F, 5'h1C}},
    '{ADDR_CONV, 32'h2, {7'h05, 7'h7F, 5'h1D}}, '{ADDR_CONV, 32'h4, {7'h05, 7'h7F, 5'h1E}},
    '{ADDR_CONV, 32'h6, {7'h05, 7'h7F, 5'h1F}}, '{ADDR_LUMA, 32'h7F, {MEM_A, 7'h7F, 5'h1F}},
    '{8'h18, 32'hFF, {MEM_A, 7'h7F, 5'h1F}}, '{ADDR_STATUS, 32'h3FF, {MEM_A, 7'h7F, 5'h1F}},
    '{ADDR_LUMB, 32'h15, {MEM_A, MEM_B, 5'h1F}}};
  crpc_peer_model peer_u (.extClk(extClk), .oscClk(oscClk), .leaderSync(leaderSync));
  crpc_top dut_u (
    .mclk(mclk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .externalClockInput(extClk), .internalOscClock(oscClk), .clockSourceSelectPad(clkPad),
    .roleSelectPads(roleSelectPads), .converterModePad(modePad), .leaderChipSelect_n(leadCs_n),
    .followerChipSelect_n(follCs_n), .syncFromLeader(leaderSync), .memLumA(MEM_A), .memLumB(MEM_B),
    .convFlags(flags), .clockOutToSlaves(clockOutToSlaves), .sysTick(sysTick), .hostSelected(hostSelected),
    .followerSyncOut(followerSyncOut), .frameSyncOutputEn(frameEn), .lineSyncOutputEn(lineEn),
    .serialForwardOutputEn(fwdEn), .rowControlFirstEn(rowFirstEn), .rowControlSecond(rowSecond),
    .rowControlSecondEn(rowSecondEn), .dacA(dacA), .dacB(dacB), .drive(drive));
  // ****************************************
  // clock, pulse counters and tasks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // count sync and tick pulses seen on the block's outputs
  always @(posedge mclk) begin
    nFollSync <= nFollSync + int'(followerSyncOut === 1'b1);
    nTick <= nTick + int'(sysTick === 1'b1);
  end
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  // one single ahb transfer: address phase, then data phase
  task automatic busXfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : busXfer
  task automatic doReset;
    @(posedge mclk);
    arst_n <= 1'b0;
    idle(8);
    arst_n <= 1'b1;
    idle(10);
  endtask : doReset
  // time between two rises of the forwarded clock, skipping the first
  task automatic period(output logic [31:0] q);
    realtime t0;
    repeat (2) @(posedge clockOutToSlaves);
    t0 = $realtime;
    @(posedge clockOutToSlaves);
    q = $rtoi($realtime - t0);
  endtask : period
  task automatic finishTest;
    if (nErrors == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finishTest
  // watchdog well beyond the expected run length
  initial begin
    #600000;
    nErrors++;
    finishTest;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    doReset;
    `CHECK_EQ({hreadyout, hresp, dacA, dacB, drive.gateEn}, {2'b10, MEM_A, MEM_B, 1'b0})
    busXfer(ADDR_LUMA, 1'b0, 32'h0, rdata);
    `CHECK_EQ(rdata, 32'h0)
    foreach (rows[i]) begin
      busXfer(rows[i].a, 1'b1, rows[i].d, rdata);
      idle(2);
      `CHECK_EQ({dacA, dacB, drive.fwdOffset, drive.freqSel}, rows[i].e)
    end
    busXfer(8'h18, 1'b0, 32'h0, rdata);
    `CHECK_EQ(rdata, 32'h0)
    busXfer(ADDR_CONV, 1'b1, 32'h1, rdata);
    idle(12);
    `CHECK_EQ(drive.gateEn, 1'b1)
    @(posedge mclk);
    modePad <= 1'b1;
    flags <= 7'h23;
    idle(10);
    `CHECK_EQ({drive.constOnTime, drive.steadyLoop, rowSecond, rowSecondEn}, 4'hF)
    busXfer(ADDR_STATUS, 1'b0, 32'h0, rdata);
    `CHECK_EQ(rdata[9:6], 4'hD)
    @(posedge mclk) flags <= 7'h60;
    @(posedge mclk) flags <= 7'h20;
    idle(10);
    `CHECK_EQ({drive.constOnTime, drive.gateEn}, 2'b11)
    @(posedge mclk) flags <= 7'h40;
    idle(12);
    `CHECK_EQ(drive.gateEn, 1'b0)
    @(posedge mclk) flags <= 7'h00;
    idle(12);
    `CHECK_EQ(drive.gateEn, 1'b0)
    @(posedge mclk) flags <= 7'h20;
    idle(12);
    `CHECK_EQ(drive.gateEn, 1'b1)
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) flags <= 7'h20 | (7'h04 << i);
      idle(i == 2 ? 5 : 10);
      `CHECK_EQ(drive.gateEn, 1'b0)
      @(posedge mclk) flags <= 7'h20;
      idle(10);
      `CHECK_EQ(drive.gateEn, 1'b1)
    end
    @(posedge mclk) flags <= 7'h30;
    idle(400);
    @(posedge mclk) flags <= 7'h20;
    busXfer(ADDR_CONV, 1'b1, 32'h1, rdata);
    busXfer(ADDR_STATUS, 1'b0, 32'h0, rdata);
    `CHECK_EQ({rdata[4], drive.gateEn}, 2'b10)
    doReset;
    busXfer(ADDR_STATUS, 1'b0, 32'h0, rdata);
    `CHECK_EQ(rdata[4], 1'b0)
    for (int n = 0; n < 8; n++) begin
      busXfer(ADDR_CLKDIV, 1'b1, 32'(n), rdata);
      period(p);
      `CHECK_EQ(p, 32'd80 << n)
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      roleSelectPads <= 2'(r);
      clkPad <= 1'b1;
      doReset;
      @(posedge mclk) leadCs_n <= 1'b0;
      idle(4);
      `CHECK_EQ({frameEn, lineEn, fwdEn, rowFirstEn, hostSelected}, {{4{r == 3}}, r[0]})
      fs0 = nFollSync;
      tk0 = nTick;
      @(posedge mclk);
      leadCs_n <= 1'b1;
      follCs_n <= 1'b0;
      roleSelectPads <= ~2'(r);
      idle(600);
      `CHECK_EQ({hostSelected, nFollSync != fs0, nTick != tk0}, {~r[0], r == 1, 1'b1})
      busXfer(ADDR_STATUS, 1'b0, 32'h0, rdata);
      `CHECK_EQ(rdata[2:0], {r[0], 2'(r)})
      @(posedge mclk) follCs_n <= 1'b1;
      period(p);
      `CHECK_EQ(p, r[0] ? 32'd208 : 32'd80)
    end
    finishTest;
  end
endmodule : clock_role_power_control_tb
